// ---- hdl/wtca_pkg.sv ----
// package of constants and types for the wide timer core
package wtca_pkg;
    localparam logic [15:0] WTCA_BOTTOM = 16'h0000;
    localparam logic [15:0] WTCA_MAX = 16'hFFFF;
    // byte address selects on the 8-bit data bus
    localparam logic [2:0] WTCA_SEL_CNT_LO = 3'h0;
    localparam logic [2:0] WTCA_SEL_CNT_HI = 3'h1;
    localparam logic [2:0] WTCA_SEL_CMPA_LO = 3'h2;
    localparam logic [2:0] WTCA_SEL_CMPA_HI = 3'h3;
    localparam logic [2:0] WTCA_SEL_CMPB_LO = 3'h4;
    localparam logic [2:0] WTCA_SEL_CMPB_HI = 3'h5;
    localparam logic [2:0] WTCA_SEL_CAP_LO = 3'h6;
    localparam logic [2:0] WTCA_SEL_CAP_HI = 3'h7;
    // flag and mask bit positions
    localparam int WTCA_FLG_OVF = 0;
    localparam int WTCA_FLG_CMPA = 1;
    localparam int WTCA_FLG_CMPB = 2;
    localparam int WTCA_FLG_CAP = 3;
    localparam logic [3:0] WTCA_FLAGS_RST = 4'h0;
    // noise filter needs this many equal samples
    localparam int WTCA_FILTER_LEN = 4;
    typedef enum logic [1:0] {
        WTCA_TOP_MAX,
        WTCA_TOP_CMPA,
        WTCA_TOP_CAP
    } wtca_top_t;
    typedef enum logic [1:0] {
        WTCA_CLK_NONE,
        WTCA_CLK_PRESCALE,
        WTCA_CLK_EXT_FALL,
        WTCA_CLK_EXT_RISE
    } wtca_clk_t;
    typedef struct packed {
        logic [2:0] sel;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } wtca_bus_t;
    typedef struct packed {
        logic cap_rise;
        logic cap_filter;
        logic cap_from_comp;
        wtca_top_t top_src;
        wtca_clk_t clk_src;
        logic pwm_mode;
    } wtca_cfg_t;
endpackage

// ---- hdl/wtca_timer.sv ----
// one instance of the wide timer core with byte access logic
`timescale 1ns/1ps
// Overview of operation
// - bottom is reached when count becomes all zeros
// - maximum is reached when count becomes all ones
// - top comes from max, compare A or capture per mode
// - compare A as top drives no pwm output, stays buffered
// - capture register may serve as top, freeing compare A
// - tick from prescaler or external pin edge; none stops counter
// - both buffered compares checked continuously, feed waveform
// - compare match sets its compare match flag
// - four flags in one register, each masked alone
// - selected capture edge stores count into capture register, except when capture is top
// - optional noise filter on the capture path
// - one shared 8-bit high-byte latch per instance
// - low byte write commits latch and low byte together
// - count and capture low byte reads copy high byte into latch
// - compare high byte reads bypass the latch
// - both instances share this same module
// - cpu write to count beats any count action
// - capture flag set in the same cycle as capture
module wtca_timer
    import wtca_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic power_gate,
    input wire wtca_pkg::wtca_bus_t bus,
    input wire wtca_pkg::wtca_cfg_t cfg,
    input wire logic [3:0] flag_clear,
    input wire logic [3:0] timer_mask_reg,
    input wire logic prescale_tick,
    input wire logic external_count_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    output logic [7:0] rdata,
    output logic [3:0] timer_flag_reg,
    output logic [3:0] irq,
    output logic [1:0] compare_output_pins
);
    import wtca_pkg::*;

    logic [15:0] count_value, next_count_value;
    logic [15:0] compare_value_a, next_compare_value_a;
    logic [15:0] compare_value_b, next_compare_value_b;
    logic [15:0] buf_a, next_buf_a;
    logic [15:0] buf_b, next_buf_b;
    logic [15:0] capture_value, next_capture_value;
    logic [7:0] hi_latch, next_hi_latch;
    logic [7:0] next_rdata;
    logic [3:0] next_flags;
    logic [3:0] next_irq;
    logic [1:0] next_pins;
    logic [1:0] ext_sync, cap_sync, cmp_sync;
    logic ext_prev, next_ext_prev;
    logic [WTCA_FILTER_LEN-1:0] cap_hist, next_cap_hist;
    logic cap_level, next_cap_level;
    logic tick, active, cap_raw, cap_filt, cap_evt;
    logic [15:0] top;
    logic at_top, match_a, match_b;

    // pin inputs pass two flops before anything reads them
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ext_sync <= 2'h0;
            cap_sync <= 2'h0;
            cmp_sync <= 2'h0;
        end else begin
            ext_sync <= {ext_sync[0], external_count_pin};
            cap_sync <= {cap_sync[0], capture_input_pin};
            cmp_sync <= {cmp_sync[0], comparator_out};
        end
    end

    assign active = !power_gate;
    always_comb begin
        case (cfg.clk_src)
            WTCA_CLK_PRESCALE: tick = prescale_tick;
            WTCA_CLK_EXT_RISE: tick = ext_sync[1] && !ext_prev;
            WTCA_CLK_EXT_FALL: tick = !ext_sync[1] && ext_prev;
            default: tick = 1'b0;
        endcase
        case (cfg.top_src)
            WTCA_TOP_CMPA: top = compare_value_a;
            WTCA_TOP_CAP: top = capture_value;
            default: top = WTCA_MAX;
        endcase
        at_top = (count_value == top);
        match_a = (count_value == compare_value_a);
        match_b = (count_value == compare_value_b);
        cap_raw = cfg.cap_from_comp ? cmp_sync[1] : cap_sync[1];
        // filter trades latency for spike rejection
        cap_filt = cfg.cap_filter ? cap_level : cap_raw;
    end

    always_comb begin
        next_ext_prev = ext_sync[1];
        next_cap_hist = {cap_hist[WTCA_FILTER_LEN-2:0], cap_raw};
        next_cap_level = cap_level;
        if (&next_cap_hist) begin
            next_cap_level = 1'b1;
        end else if (~|next_cap_hist) begin
            next_cap_level = 1'b0;
        end
    end

    logic cap_prev, next_cap_prev;
    assign next_cap_prev = cap_filt;
    assign cap_evt = active && (cfg.cap_rise ? (cap_filt && !cap_prev)
                                             : (!cap_filt && cap_prev));

    always_comb begin
        next_count_value = count_value;
        next_compare_value_a = compare_value_a;
        next_compare_value_b = compare_value_b;
        next_buf_a = buf_a;
        next_buf_b = buf_b;
        next_capture_value = capture_value;
        next_hi_latch = hi_latch;
        next_rdata = 8'h00;
        next_flags = timer_flag_reg & ~flag_clear;
        if (active && tick) begin
            if (at_top) begin
                next_count_value = WTCA_BOTTOM;
                // compare units reload from buffers at the period end
                next_compare_value_a = buf_a;
                next_compare_value_b = buf_b;
            end else begin
                next_count_value = count_value + 16'h0001;
            end
            // set wins over a same-cycle clear
            if (at_top) begin
                next_flags[WTCA_FLG_OVF] = 1'b1;
            end
            if (match_a) begin
                next_flags[WTCA_FLG_CMPA] = 1'b1;
            end
            if (match_b) begin
                next_flags[WTCA_FLG_CMPB] = 1'b1;
            end
        end
        if (cap_evt && cfg.top_src != WTCA_TOP_CAP) begin
            next_capture_value = count_value;
            next_flags[WTCA_FLG_CAP] = 1'b1;
        end
        if (!cfg.pwm_mode) begin
            next_compare_value_a = next_buf_a;
            next_compare_value_b = next_buf_b;
        end
        if (bus.wr) begin
            if (bus.sel[0]) begin
                next_hi_latch = bus.wdata;
            end else if (bus.sel == WTCA_SEL_CNT_LO) begin
                next_count_value = {hi_latch, bus.wdata};
            end else if (bus.sel == WTCA_SEL_CMPA_LO) begin
                next_buf_a = {hi_latch, bus.wdata};
            end else if (bus.sel == WTCA_SEL_CMPB_LO) begin
                next_buf_b = {hi_latch, bus.wdata};
            end else begin
                next_capture_value = {hi_latch, bus.wdata};
            end
        end else if (bus.rd) begin
            if (bus.sel == WTCA_SEL_CNT_LO) begin
                next_rdata = count_value[7:0];
                next_hi_latch = count_value[15:8];
            end else if (bus.sel == WTCA_SEL_CAP_LO) begin
                next_rdata = capture_value[7:0];
                next_hi_latch = capture_value[15:8];
            end else if (bus.sel == WTCA_SEL_CMPA_LO) begin
                next_rdata = buf_a[7:0];
            end else if (bus.sel == WTCA_SEL_CMPB_LO) begin
                next_rdata = buf_b[7:0];
            end else if (bus.sel == WTCA_SEL_CMPA_HI) begin
                next_rdata = buf_a[15:8];
            end else if (bus.sel == WTCA_SEL_CMPB_HI) begin
                next_rdata = buf_b[15:8];
            end else begin
                next_rdata = hi_latch;
            end
        end
        next_irq = next_flags & timer_mask_reg;
        next_pins = compare_output_pins;
        if (active && tick) begin
            // compare A used as top gives no waveform in pwm mode
            if (match_a && !(cfg.pwm_mode && cfg.top_src == WTCA_TOP_CMPA)) begin
                next_pins[0] = !compare_output_pins[0];
            end
            if (match_b) begin
                next_pins[1] = !compare_output_pins[1];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            count_value <= 16'h0000;
            compare_value_a <= 16'h0000;
            compare_value_b <= 16'h0000;
            buf_a <= 16'h0000;
            buf_b <= 16'h0000;
            capture_value <= 16'h0000;
            hi_latch <= 8'h00;
            rdata <= 8'h00;
            timer_flag_reg <= WTCA_FLAGS_RST;
            irq <= 4'h0;
            compare_output_pins <= 2'h0;
            ext_prev <= 1'b0;
            cap_hist <= '0;
            cap_level <= 1'b0;
            cap_prev <= 1'b0;
        end else begin
            count_value <= next_count_value;
            compare_value_a <= next_compare_value_a;
            compare_value_b <= next_compare_value_b;
            buf_a <= next_buf_a;
            buf_b <= next_buf_b;
            capture_value <= next_capture_value;
            hi_latch <= next_hi_latch;
            rdata <= next_rdata;
            timer_flag_reg <= next_flags;
            irq <= next_irq;
            compare_output_pins <= next_pins;
            ext_prev <= next_ext_prev;
            cap_hist <= next_cap_hist;
            cap_level <= next_cap_level;
            cap_prev <= next_cap_prev;
        end
    end
endmodule

// ---- dv/wtca_cpu.sv ----
// cpu core model driving the timer byte bus
`timescale 1ns/1ps
module wtca_cpu
    import wtca_pkg::*;
(
    input wire logic mclk,
    input wire logic [7:0] rdata,
    output wtca_pkg::wtca_bus_t bus
);
    logic [7:0] q;
    initial bus = '0;
    // request held until the taking edge, answer taken just after it
    task automatic acc(input [2:0] s, input w, input [7:0] d);
        bus = '{s, w, !w, d};
        @(posedge mclk);
        #1;
        q = rdata;
    endtask
    // a released data bus shows the inverse, never the last byte
    task automatic idle();
        bus = '{bus.sel, 1'b0, 1'b0, ~bus.wdata};
        @(posedge mclk);
        #1;
    endtask
    task automatic wr16(input [2:0] lo, input [15:0] v);
        acc(lo | 3'h1, 1'b1, v[15:8]);
        acc(lo, 1'b1, v[7:0]);
        idle();
    endtask
    task automatic rd16(input [2:0] lo, output [15:0] v);
        acc(lo, 1'b0, 8'h00);
        v[7:0] = q;
        acc(lo | 3'h1, 1'b0, 8'h00);
        v[15:8] = q;
        idle();
    endtask
endmodule

// ---- dv/wtca_timer_chk.sv ----
// port assertions for the wide timer core
`timescale 1ns/1ps
module wtca_timer_chk
    import wtca_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_n,
    input wire wtca_pkg::wtca_bus_t bus,
    input wire wtca_pkg::wtca_cfg_t cfg,
    input wire logic [3:0] flag_clear,
    input wire logic [3:0] timer_mask_reg,
    input wire logic [7:0] rdata,
    input wire logic [3:0] timer_flag_reg,
    input wire logic [3:0] irq
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);
    wire rd_only = bus.rd && !bus.wr;
    AST_RST_QUIET: assert property (disable iff (1'b0)
        !rst_n |=> timer_flag_reg == 4'h0 && irq == 4'h0 && rdata == 8'h00)
        else $error("outputs not quiet in reset");
    // irq may follow the flags in the same or the next cycle
    AST_IRQ_MASK: assert property (
        irq == (timer_flag_reg & $past(timer_mask_reg))
        || irq == $past(timer_flag_reg & timer_mask_reg))
        else $error("irq differs from masked flags");
    AST_RD_IDLE: assert property (
        !rd_only |=> rdata == 8'h00) else $error("rdata without read");
    AST_FLAG_HOLD: assert property (
        timer_flag_reg != 4'h0 |=>
        ($past(timer_flag_reg) & ~$past(flag_clear) & ~timer_flag_reg) == 4'h0)
        else $error("flag dropped without clear");
    AST_FLAG_CLR: assert property (
        flag_clear[WTCA_FLG_OVF] && cfg.clk_src == WTCA_CLK_NONE
        |=> !timer_flag_reg[WTCA_FLG_OVF]) else $error("flag not cleared");
    AST_LATCH_SHARE: assert property (
        bus.wr && bus.sel == WTCA_SEL_CMPA_HI ##1
        rd_only && bus.sel == WTCA_SEL_CNT_HI
        |=> rdata == $past(bus.wdata, 2)) else $error("latch not shared");
    AST_CMP_DIRECT: assert property (
        bus.wr && bus.sel == WTCA_SEL_CMPA_HI ##1
        bus.wr && bus.sel == WTCA_SEL_CMPA_LO ##1
        rd_only && bus.sel == WTCA_SEL_CMPA_HI && !cfg.pwm_mode
        |=> rdata == $past(bus.wdata, 3)) else $error("compare high wrong");
    AST_CNT_WRITE: assert property (
        bus.wr && bus.sel == WTCA_SEL_CNT_LO && cfg.clk_src == WTCA_CLK_NONE
        ##1 !bus.wr ##1 rd_only && bus.sel == WTCA_SEL_CNT_LO
        |=> rdata == $past(bus.wdata, 3)) else $error("count write lost");
endmodule
bind wtca_timer wtca_timer_chk chk_u (.mclk, .rst_n, .bus, .cfg, .flag_clear,
    .timer_mask_reg, .rdata, .timer_flag_reg, .irq);

// ---- dv/wide_timer_core_access_bench.sv ----
// self-checking bench for the wide timer core
`timescale 1ns/1ps
module wide_timer_core_access_bench;
    import wtca_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, prescale_tick = 1'b0;
    logic power_gate = 1'b0;
    logic external_count_pin = 1'b0, capture_input_pin = 1'b0;
    logic comparator_out = 1'b0;
    logic [3:0] flag_clear = 4'h0, timer_mask_reg = 4'h1;
    wtca_bus_t bus;
    wtca_cfg_t cfg = '0;
    logic [7:0] rdata;
    logic [3:0] timer_flag_reg, irq;
    logic [1:0] compare_output_pins;
    logic [15:0] v;
    int n_mismatch = 0, compares = 0;
    always #2.5 mclk = ~mclk;
    wtca_timer dut_u (.mclk, .rst_n, .power_gate, .bus, .cfg, .flag_clear,
        .timer_mask_reg, .prescale_tick, .external_count_pin,
        .capture_input_pin, .comparator_out, .rdata, .timer_flag_reg, .irq,
        .compare_output_pins);
    wtca_cpu cpu_u (.mclk, .rdata, .bus);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %0t %h %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // ticks only while the prescaler is selected, stopped otherwise
    task automatic tick(input int n);
        cfg.clk_src = WTCA_CLK_PRESCALE;
        repeat (n) begin
            prescale_tick = 1'b1;
            cyc(1);
            prescale_tick = 1'b0;
            cyc(1);
        end
        cfg.clk_src = WTCA_CLK_NONE;
        cyc(1);
    endtask
    task automatic print_verdict();
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #20000;
        n_mismatch++;
        print_verdict();
    end
    initial begin
        cyc(5);
        rst_n = 1'b1;
        cyc(1);
        for (int k = 0; k < 8; k += 2) begin
            cpu_u.wr16(3'(k), 16'h01FF + 16'(k) * 16'h0901);
            cpu_u.rd16(3'(k), v);
            chk(v, 16'h01FF + 16'(k) * 16'h0901);
        end
        cpu_u.acc(WTCA_SEL_CMPA_HI, 1'b1, 8'h5A);
        cpu_u.acc(WTCA_SEL_CMPA_LO, 1'b1, 8'hC3);
        cpu_u.acc(WTCA_SEL_CMPA_HI, 1'b0, 8'h00);
        chk(cpu_u.q, 8'h5A);
        cpu_u.acc(WTCA_SEL_CMPA_HI, 1'b1, 8'h77);
        cpu_u.acc(WTCA_SEL_CNT_HI, 1'b0, 8'h00);
        chk(cpu_u.q, 8'h77);
        cpu_u.acc(WTCA_SEL_CMPA_HI, 1'b0, 8'h00);
        chk(cpu_u.q, 8'h5A);
        cpu_u.idle();
        cpu_u.wr16(WTCA_SEL_CNT_LO, WTCA_MAX - 16'h0001);
        tick(1);
        chk(timer_flag_reg, 4'h0);
        tick(1);
        chk(timer_flag_reg, 4'h1);
        chk(irq, 4'h1);
        cpu_u.rd16(WTCA_SEL_CNT_LO, v);
        chk(v, WTCA_BOTTOM);
        cpu_u.wr16(WTCA_SEL_CMPB_LO, 16'h0010);
        cpu_u.wr16(WTCA_SEL_CNT_LO, 16'h000F);
        flag_clear = 4'h1;
        cyc(1);
        flag_clear = 4'h0;
        tick(2);
        chk(timer_flag_reg, 4'h4);
        chk(irq, 4'h0);
        chk(compare_output_pins, 2'h2);
        flag_clear = 4'hF;
        cfg.cap_rise = 1'b1;
        cfg.cap_filter = 1'b1;
        cyc(1);
        flag_clear = 4'h0;
        capture_input_pin = 1'b1;
        cyc(2);
        capture_input_pin = 1'b0;
        cyc(10);
        chk(timer_flag_reg, 4'h0);
        capture_input_pin = 1'b1;
        cyc(10);
        chk(timer_flag_reg, 4'h8);
        cpu_u.rd16(WTCA_SEL_CAP_LO, v);
        chk(v, 16'h0011);
        // a gated instance must ignore ticks
        power_gate = 1'b1;
        tick(1);
        power_gate = 1'b0;
        cpu_u.rd16(WTCA_SEL_CNT_LO, v);
        chk(v, 16'h0011);
        // only the rising edge of the external pin counts
        cfg.clk_src = WTCA_CLK_EXT_RISE;
        external_count_pin = 1'b1;
        cyc(5);
        external_count_pin = 1'b0;
        cyc(5);
        cfg.clk_src = WTCA_CLK_NONE;
        cyc(1);
        cpu_u.rd16(WTCA_SEL_CNT_LO, v);
        chk(v, 16'h0012);
        // compare a as top in pwm mode wraps the count, no waveform
        cpu_u.wr16(WTCA_SEL_CMPA_LO, 16'h0014);
        cfg.pwm_mode = 1'b1;
        cfg.top_src = WTCA_TOP_CMPA;
        flag_clear = 4'hF;
        cyc(1);
        flag_clear = 4'h0;
        tick(3);
        chk(timer_flag_reg, 4'h3);
        chk(compare_output_pins, 2'h2);
        cpu_u.rd16(WTCA_SEL_CNT_LO, v);
        chk(v, WTCA_BOTTOM + 16'h0000);
        print_verdict();
    end
endmodule
